//--- node_message_mailbox.sv
// node message mailbox top: two mailboxes, local and upstream interrupts, master report
`timescale 1ns/1ps
module node_message_mailbox (
  input  wire logic        ref_clk,       // system clock, 100 MHz
  input  wire logic        reset,         // async reset, active high
  input  wire logic        master_strap,  // pin: high selects master role
  input  wire logic [7:0]  loc_addr,      // local register address
  input  wire logic        loc_wr,        // local write pulse
  input  wire logic        loc_rd,        // local read pulse
  input  wire logic [7:0]  loc_wdata,     // local write data
  output logic      [7:0]  loc_rdata,     // local read data, next cycle
  input  wire logic [7:0]  rem_addr,      // remote (host) register address
  input  wire logic        rem_wr,        // remote write pulse
  input  wire logic        rem_rd,        // remote read pulse
  input  wire logic [7:0]  rem_wdata,     // remote write data
  output logic      [7:0]  rem_rdata,     // remote read data, next cycle
  input  wire logic        scf_strobe,    // downstream control field pulse
  input  wire logic        srf_strobe,    // upstream response field pulse
  input  wire logic        host_clear,    // clear of our upstream request
  output logic             interrupt_pin, // interrupt pin level
  output logic             up_irq,        // upstream response field request
  output logic      [7:0]  up_type,       // type carried upstream
  input  wire logic [15:0] node_pending,  // master: per-node pending requests
  input  wire logic [127:0] node_type,    // master: per-node type codes
  output logic             clear_req,     // master: clear pulse to a slave
  output logic      [3:0]  clear_node,    // master: slave to clear
  output logic      [3:0]  target_node,   // remote access target node
  output logic             target_peri,   // remote access goes to peripheral
  output logic             target_brcst   // remote write broadcast
);
  //////////////////////////////////////////////////////////////////////////////
  // strap passes two flops before use
  logic strap_meta;
  logic master_mode;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      strap_meta  <= 1'b0;
      master_mode <= 1'b0;
    end
    else
    begin
      strap_meta  <= master_strap;
      master_mode <= strap_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode shared by both access ports
  function automatic logic mb_hit(input logic [7:0] a, input logic mb);
    mb_hit = a[7:3] == (mbx_pkg::MB0_BASE[7:3] + (mb ? mbx_pkg::MB_STRIDE[7:3] : 5'h00));
  endfunction
  function automatic logic is_data(input logic [7:0] a);
    is_data = a[2:0] >= mbx_pkg::OFF_B0 && a[2:0] < mbx_pkg::OFF_B0 + 3'h4;
  endfunction
  function automatic logic [1:0] idx_of(input logic [7:0] a);
    idx_of = 2'(a[2:0] - mbx_pkg::OFF_B0);
  endfunction

  logic [7:0]  ctl        [0:1];
  logic [7:0]  status     [0:1];
  logic [31:0] bytes      [0:1];
  logic [1:0]  fill_flag;
  logic [1:0]  drain_flag;
  logic [1:0]  clr_fill;
  logic [1:0]  clr_drain;

  // two identical mailboxes; a remote access wins over a local one in a cycle
  for (genvar i = 0; i < 2; i++)
  begin : g_mb
    wire       rem_sel = mb_hit(rem_addr, i[0]) && (rem_wr || rem_rd);
    wire [7:0] a       = rem_sel ? rem_addr : loc_addr;
    wire       wr      = rem_sel ? rem_wr : loc_wr && mb_hit(loc_addr, i[0]);
    wire       rd      = rem_sel ? rem_rd : loc_rd && mb_hit(loc_addr, i[0]);
    mailbox_unit #(
      .CTL_RESET (i == 0 ? mbx_pkg::CTL0_RESET : mbx_pkg::CTL1_RESET)  // RQ2
    ) u_mb (  // RQ1
      .ref_clk    (ref_clk),
      .reset      (reset),
      .ctl_wr     (wr && a[2:0] == mbx_pkg::OFF_CTL),
      .data_wr    (wr && is_data(a)),
      .data_rd    (rd && is_data(a)),
      .byte_idx   (idx_of(a)),
      .wdata      (rem_sel ? rem_wdata : loc_wdata),
      .by_host    (rem_sel),
      .clr_fill   (clr_fill[i]),
      .clr_drain  (clr_drain[i]),
      .ctl        (ctl[i]),
      .status     (status[i]),
      .bytes      (bytes[i]),
      .fill_flag  (fill_flag[i]),
      .drain_flag (drain_flag[i])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // route each flag: receive fill and transmit drain go to the node,
  // receive drain and transmit fill go upstream to the host
  wire [1:0] dir_bits = {ctl[1][mbx_pkg::CTL_DIR], ctl[0][mbx_pkg::CTL_DIR]};
  wire [1:0] loc_fill = fill_flag & ~dir_bits;    // RQ5
  wire [1:0] loc_drn  = drain_flag & dir_bits;    // RQ8
  wire [1:0] up_fill  = fill_flag & dir_bits;     // RQ7
  wire [1:0] up_drn   = drain_flag & ~dir_bits;   // RQ6
  wire       loc_any  = |{loc_fill, loc_drn};
  wire       up_any   = |{up_fill, up_drn};

  // fixed priority: mailbox zero before one, fill before drain
  function automatic logic [7:0] pick(input logic [1:0] f, input logic [1:0] d);
    if (f[0])      pick = mbx_pkg::mbx_code(1'b0, 1'b0);
    else if (d[0]) pick = mbx_pkg::mbx_code(1'b0, 1'b1);
    else if (f[1]) pick = mbx_pkg::mbx_code(1'b1, 1'b0);
    else if (d[1]) pick = mbx_pkg::mbx_code(1'b1, 1'b1);
    else           pick = mbx_pkg::TYPE_NONE;
  endfunction

  wire [7:0] lint_code = pick(loc_fill, loc_drn);
  wire       lint_read = loc_rd && loc_addr == mbx_pkg::ADDR_LINT;  // RQ21
  wire       up_done   = host_clear && up_irq;

  // processing: a local type read clears the reported flag, a host clear the upstream one
  for (genvar i = 0; i < 2; i++)
  begin : g_clr
    assign clr_fill[i]  = (lint_read && lint_code == mbx_pkg::mbx_code(i[0], 1'b0))
                          || (up_done && up_type == mbx_pkg::mbx_code(i[0], 1'b0));  // RQ12
    assign clr_drain[i] = (lint_read && lint_code == mbx_pkg::mbx_code(i[0], 1'b1))
                          || (up_done && up_type == mbx_pkg::mbx_code(i[0], 1'b1));  // RQ12
  end

  //////////////////////////////////////////////////////////////////////////////
  // local pin: a remote write raises it at once, otherwise it waits for the next
  // control field; it drops as soon as nothing local is pending
  // the fill flag only shows the cycle after the write, so the write is kept one cycle
  logic lpin;
  logic host_wrote;
  wire  next_lpin = loc_any && (lpin || scf_strobe || rem_wr || host_wrote);  // RQ18 RQ19
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      lpin       <= 1'b0;
      host_wrote <= 1'b0;
    end
    else
    begin
      lpin       <= next_lpin;
      host_wrote <= rem_wr;  // RQ18
    end
  end

  // upstream request is only loaded in a response field and held until cleared,
  // which can cost one extra superframe of latency
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      up_irq  <= 1'b0;
      up_type <= mbx_pkg::TYPE_NONE;
    end
    else if (up_done)
      up_irq  <= 1'b0;
    else if (srf_strobe && !up_irq && up_any)
    begin
      up_irq  <= 1'b1;  // RQ17
      up_type <= pick(up_fill, up_drn);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // master report: lowest node number is nearest, and a node just cleared is
  // masked until its request drops so a stale level is not reported twice
  logic [15:0] blocked;
  logic        m_valid;
  logic [7:0]  int_type;
  logic [3:0]  int_src;
  wire  [15:0] eligible = node_pending & ~blocked;

  function automatic logic [3:0] first_set(input logic [15:0] v);
    first_set = 4'h0;
    for (int k = 15; k >= 0; k--)
      if (v[k]) first_set = 4'(k);
  endfunction

  wire [3:0] pick_node = first_set(eligible);                       // RQ14
  wire       type_read = master_mode && loc_rd && loc_addr == mbx_pkg::ADDR_TYPE;
  wire       do_clear  = type_read && m_valid;                      // RQ15
  wire       do_load   = master_mode && !m_valid && (|eligible);
  wire       next_mirq = do_load;                                   // RQ16
  logic      mirq;

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      m_valid  <= 1'b0;
      int_type <= mbx_pkg::TYPE_NONE;
      int_src  <= 4'h0;
    end
    else if (do_clear)
      m_valid  <= 1'b0;  // RQ16
    else if (do_load)
    begin
      m_valid  <= 1'b1;  // RQ13
      int_type <= node_type[{pick_node, 3'h0} +: 8];
      int_src  <= pick_node;
    end
  end

  // pin follows the report; the clearing cycle forces one low cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      mirq <= 1'b0;
    else
      mirq <= (mirq && !do_clear) || next_mirq;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      blocked <= 16'h0000;
    else
      blocked <= (blocked & node_pending) | (do_clear ? 16'(1) << int_src : 16'h0000);
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      clear_req     <= 1'b0;
      clear_node    <= 4'h0;
      interrupt_pin <= 1'b0;
    end
    else
    begin
      clear_req     <= do_clear;  // RQ15
      clear_node    <= do_clear ? int_src : clear_node;  // holds the last slave cleared
      interrupt_pin <= master_mode ? ((mirq && !do_clear) || next_mirq) : next_lpin;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // node address register, written by the host in master role
  logic [7:0] node_addr;
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      node_addr <= mbx_pkg::NODE_RESET;
    else if (master_mode && loc_wr && loc_addr == mbx_pkg::ADDR_NODE)
      node_addr <= loc_wdata;  // RQ22 RQ20
  end
  assign target_node  = node_addr[3:0];               // RQ22
  assign target_peri  = node_addr[mbx_pkg::NA_PERI];
  assign target_brcst = node_addr[mbx_pkg::NA_BRCST];

  //////////////////////////////////////////////////////////////////////////////
  // read back, unmapped addresses read zero
  function automatic logic [7:0] read_value(input logic [7:0] a);
    read_value = 8'h00;
    for (int m = 0; m < 2; m++)
      if (mb_hit(a, m[0]))
      begin
        if (a[2:0] == mbx_pkg::OFF_CTL)  read_value = ctl[m];
        if (a[2:0] == mbx_pkg::OFF_STAT) read_value = status[m];
        if (is_data(a))                  read_value = bytes[m][{idx_of(a), 3'h0} +: 8];
      end
    if (a == mbx_pkg::ADDR_LINT) read_value = lint_code;
    if (a == mbx_pkg::ADDR_TYPE) read_value = master_mode && m_valid ? int_type : 8'h00;
    if (a == mbx_pkg::ADDR_SRC)  read_value = master_mode ? 8'(int_src) : 8'h00;
    if (a == mbx_pkg::ADDR_NODE) read_value = node_addr;
  endfunction

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      loc_rdata <= 8'h00;
      rem_rdata <= 8'h00;
    end
    else
    begin
      loc_rdata <= loc_rd ? read_value(loc_addr) : loc_rdata;
      rem_rdata <= rem_rd ? read_value(rem_addr) : rem_rdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  sequence s_clear_read;
    master_mode && do_clear;
  endsequence
  sequence s_pin_gap;
    !interrupt_pin;
  endsequence

  pin_drops_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ16
    s_clear_read |=> s_pin_gap) else $error("pin did not drop after clearing read");
  clear_pulse_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ15
    s_clear_read |=> clear_req && clear_node == $past(int_src))
    else $error("clearing read sent no clear to source");
  nearest_first_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ14
    do_load |=> ($past(eligible) & ((16'(1) << int_src) - 16'(1))) == 16'h0000)
    else $error("nearer node not reported");
  lpin_cause_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ18
    !master_mode && $rose(lpin) |-> $past(scf_strobe) || $past(rem_wr) || $past(rem_wr, 2))
    else $error("local pin rose outside control field or remote write");
  up_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ17
    up_irq && !host_clear |=> up_irq) else $error("upstream request dropped uncleared");
  up_in_srf_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ17
    $rose(up_irq) |-> $past(srf_strobe)) else $error("upstream request outside response field");
endmodule // node_message_mailbox

//--- mbx_pkg.sv
// constants shared by the node message mailbox design
// What this block does
// [RQ1] two independent mailboxes with identical behaviour
// [RQ2] after reset mailbox zero receives and mailbox one transmits
// [RQ3] direction bit: 0 receive, 1 transmit; separate enable bit activates the mailbox
// [RQ4] two-bit length: 0b00 one byte up to 0b11 four, starting at byte zero
// [RQ5] enabled receive with fill enable interrupts the node after host writes final byte
// [RQ6] enabled receive with drain enable interrupts host after local read of final byte
// [RQ7] enabled transmit with fill enable interrupts host after local write of final byte
// [RQ8] enabled transmit with drain enable interrupts node after host reads final byte
// [RQ9] software disables a mailbox before reconfiguring, then re-enables in a second access
// [RQ10] on fill, full flag sets and empty flag clears
// [RQ11] on drain, empty flag sets and full flag clears
// [RQ12] fill and drain interrupt flags set on signalling, clear when processed
// [RQ13] master reports pending slave interrupt type and its source node
// [RQ14] simultaneous slave interrupts: nearer slave reported first
// [RQ15] host read of type register clears that request in the source slave
// [RQ16] after a clearing read, master pin drops then reasserts for another pending slave
// [RQ17] slave to master requests travel in the upstream response field
// [RQ18] remote mailbox writes raise the local interrupt at once, without waiting for the control field
// [RQ19] host read of last transmit byte raises local drain interrupt at next control field
// [RQ20] host sets node address before remote reads of a slave mailbox
// [RQ21] node processor reads local interrupt type before touching mailbox data
// [RQ22] node address steers remote accesses; peripheral bit and broadcast bit select target
// [RQ23] data byte registers store and return bytes; final byte access detects fill or drain
package mbx_pkg;
  // register map of one mailbox, mailbox one sits MB_STRIDE above mailbox zero
  localparam logic [7:0] MB0_BASE  = 8'h00;
  localparam logic [7:0] MB_STRIDE = 8'h08;
  localparam logic [2:0] OFF_CTL   = 3'h0;
  localparam logic [2:0] OFF_STAT  = 3'h1;
  localparam logic [2:0] OFF_B0    = 3'h2;
  localparam logic [7:0] ADDR_LINT = 8'h10;
  localparam logic [7:0] ADDR_TYPE = 8'h11;
  localparam logic [7:0] ADDR_SRC  = 8'h12;
  localparam logic [7:0] ADDR_NODE = 8'h13;
  // control register fields
  localparam int CTL_EN   = 0;
  localparam int CTL_DIR  = 1;
  localparam int CTL_LEN  = 2;
  localparam int CTL_FIEN = 4;
  localparam int CTL_EIEN = 5;
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [7:0] CTL1_RESET = 8'h02;
  // status register fields
  localparam int ST_FULL  = 0;
  localparam int ST_EMPTY = 1;
  localparam int ST_FIRQ  = 4;
  localparam int ST_EIRQ  = 5;
  // node address register fields
  localparam int NA_PERI  = 5;
  localparam int NA_BRCST = 7;
  localparam logic [7:0] NODE_RESET = 8'h00;
  // interrupt type codes
  localparam logic [7:0] TYPE_NONE    = 8'h00;
  localparam logic [7:0] TYPE_MB_BASE = 8'h10;
  localparam int NODE_COUNT = 16;
  localparam int NODE_W     = 4;
  // type code of a mailbox event: bit 1 mailbox, bit 0 drain
  function automatic logic [7:0] mbx_code(input logic mb, input logic drn);
    mbx_code = TYPE_MB_BASE | {6'h00, mb, drn};
  endfunction
endpackage

//--- mailbox_unit.sv
// one mailbox: control, status, four data bytes and fill / drain detection
`timescale 1ns/1ps
module mailbox_unit #(
  parameter logic [7:0] CTL_RESET = 8'h00
) (
  input  wire logic        ref_clk,    // system clock
  input  wire logic        reset,      // async reset, active high
  input  wire logic        ctl_wr,     // control register write pulse
  input  wire logic        data_wr,    // data byte write pulse
  input  wire logic        data_rd,    // data byte read pulse
  input  wire logic [1:0]  byte_idx,   // data byte addressed
  input  wire logic [7:0]  wdata,      // write data
  input  wire logic        by_host,    // access comes from the remote host
  input  wire logic        clr_fill,   // fill interrupt processed
  input  wire logic        clr_drain,  // drain interrupt processed
  output logic      [7:0]  ctl,        // control register
  output logic      [7:0]  status,     // status register
  output logic      [31:0] bytes,      // data bytes, byte zero lowest
  output logic             fill_flag,  // fill interrupt pending
  output logic             drain_flag  // drain interrupt pending
);
  logic [7:0] mem [0:3];
  logic       full;
  logic       empty;
  wire        enable    = ctl[mbx_pkg::CTL_EN];
  wire        dir       = ctl[mbx_pkg::CTL_DIR];
  wire [1:0]  len       = ctl[mbx_pkg::CTL_LEN+1:mbx_pkg::CTL_LEN];
  wire        final_hit = byte_idx == len;                       // RQ4
  // receive: host writes, node reads; transmit the other way round
  wire        writer_ok = dir ? !by_host : by_host;               // RQ3
  wire        fill_evt  = enable && data_wr && final_hit && writer_ok;   // RQ23
  wire        drain_evt = enable && data_rd && final_hit && !writer_ok;  // RQ23
  wire        disabling = ctl_wr && !wdata[mbx_pkg::CTL_EN];

  //////////////////////////////////////////////////////////////////////////////
  // control register; reconfiguration while enabled is left to software
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      ctl <= CTL_RESET;  // RQ2
    else if (ctl_wr)
      ctl <= wdata;
  end

  // data bytes are plain storage, any side may read them back
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      for (int i = 0; i < 4; i++) mem[i] <= 8'h00;
    else if (data_wr)
      mem[byte_idx] <= wdata;  // RQ23
  end

  // full and empty are mutually exclusive; disabling drops back to empty
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      full  <= 1'b0;
      empty <= 1'b1;
    end
    else if (fill_evt)
    begin
      full  <= 1'b1;  // RQ10
      empty <= 1'b0;
    end
    else if (drain_evt || disabling)
    begin
      full  <= 1'b0;  // RQ11
      empty <= 1'b1;
    end
  end

  // interrupt flags: a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      fill_flag  <= 1'b0;
      drain_flag <= 1'b0;
    end
    else
    begin
      fill_flag  <= (fill_evt && ctl[mbx_pkg::CTL_FIEN])             // RQ5 RQ7
                    || (fill_flag && !clr_fill && !disabling);        // RQ12
      drain_flag <= (drain_evt && ctl[mbx_pkg::CTL_EIEN])            // RQ6 RQ8
                    || (drain_flag && !clr_drain && !disabling);      // RQ12
    end
  end

  assign bytes = {mem[3], mem[2], mem[1], mem[0]};
  assign status = 8'h00
                  | (8'(full)       << mbx_pkg::ST_FULL)
                  | (8'(empty)      << mbx_pkg::ST_EMPTY)
                  | (8'(fill_flag)  << mbx_pkg::ST_FIRQ)
                  | (8'(drain_flag) << mbx_pkg::ST_EIRQ);

  //////////////////////////////////////////////////////////////////////////////
  full_xor_empty_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
    full != empty) else $error("full and empty both equal");
  fill_sets_full_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ10
    fill_evt |=> full && !empty) else $error("fill did not set full");
  drain_sets_empty_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ11
    drain_evt && !fill_evt |=> empty && !full) else $error("drain did not set empty");
  final_byte_fill_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ4
    enable && ctl[mbx_pkg::CTL_FIEN] && data_wr && writer_ok && byte_idx == len
    |=> fill_flag) else $error("final byte write raised no fill flag");
  flag_holds_a: assert property (@(posedge ref_clk) disable iff (reset) // RQ12
    fill_flag && !clr_fill && !disabling |=> fill_flag) else $error("fill flag lost");
endmodule // mailbox_unit

//--- frame_partner.sv
// superframe timing and upstream acknowledge model of the bus side
`timescale 1ns/1ps
module frame_partner #(
  parameter int FRAME   = 64, // cycles per superframe
  parameter int ACK_DLY = 20  // host reaction time to an upstream request
) (
  input  wire logic ref_clk,    // system clock
  input  wire logic reset,      // async reset, active high
  input  wire logic up_irq,     // upstream request from the slave
  output logic      scf_strobe, // downstream control field pulse
  output logic      srf_strobe, // upstream response field pulse
  output logic      host_clear  // host has serviced the request
);
  int cnt;
  int wait_cnt;
  ////////////////////////////////////////////////////////////////////////////////////////////
  // control field opens the frame, response field sits halfway: requests only ride the latter
  always_ff @(posedge ref_clk or posedge reset)
    if (reset)
    begin
      cnt <= 0;
      wait_cnt <= 0;
      scf_strobe <= 1'b0;
      srf_strobe <= 1'b0;
      host_clear <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == FRAME - 1) ? 0 : cnt + 1;
      scf_strobe <= (cnt == FRAME - 1);
      srf_strobe <= (cnt == FRAME / 2 - 1);
      // host waits ACK_DLY cycles before clearing, so the request is held for less than one frame
      wait_cnt <= (up_irq && !host_clear) ? wait_cnt + 1 : 0;
      host_clear <= up_irq && !host_clear && (wait_cnt == ACK_DLY);
    end
endmodule // frame_partner

//--- tb_node_message_mailbox.sv
// self-checking bench for the node message mailbox
`timescale 1ns/1ps
module tb_node_message_mailbox;
  logic         ref_clk, reset, master_strap, loc_wr, loc_rd, rem_wr, rem_rd;
  logic [7:0]   loc_addr, loc_wdata, loc_rdata, rem_addr, rem_wdata, rem_rdata, up_type, rv;
  logic         scf_strobe, srf_strobe, host_clear, interrupt_pin, up_irq, clear_req;
  logic [15:0]  node_pending;
  logic [127:0] node_type;
  logic [3:0]   clear_node, target_node;
  logic         target_peri, target_brcst;
  int           n_fail, num_checks, clr_cnt, pin_falls, i;

  node_message_mailbox uut (.ref_clk, .reset, .master_strap, .loc_addr, .loc_wr, .loc_rd,
    .loc_wdata, .loc_rdata, .rem_addr, .rem_wr, .rem_rd, .rem_wdata, .rem_rdata, .scf_strobe,
    .srf_strobe, .host_clear, .interrupt_pin, .up_irq, .up_type, .node_pending, .node_type,
    .clear_req, .clear_node, .target_node, .target_peri, .target_brcst);
  frame_partner partner (.ref_clk, .reset, .up_irq, .scf_strobe, .srf_strobe, .host_clear);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // one register access on the local (rem=0) or remote (rem=1) port; read data lands in rv
  task automatic acc(input logic rem, input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    {rem_addr, rem_wdata, rem_wr, rem_rd} = rem ? {a, d, wr, !wr} : 18'h0_0000;
    {loc_addr, loc_wdata, loc_wr, loc_rd} = rem ? 18'h0_0000 : {a, d, wr, !wr};
    @(posedge ref_clk);
    #1;
    {rem_wr, rem_rd, loc_wr, loc_rd} = 4'h0;
    rv = rem ? rem_rdata : loc_rdata;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop;
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // clock, watchdog and master-side monitors
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial
  begin
    #100000;
    n_fail++;
    report_and_stop();
  end
  always @(posedge ref_clk) if (clear_req === 1'b1) clr_cnt++;
  always @(negedge interrupt_pin) if (master_strap === 1'b1) pin_falls++;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence: slave receive, slave transmit, then master report
  initial
  begin
    {n_fail, num_checks, clr_cnt, pin_falls} = '0;
    {reset, master_strap, loc_wr, loc_rd, rem_wr, rem_rd} = 6'b10_0000;
    {loc_addr, loc_wdata, rem_addr, rem_wdata, node_pending, node_type} = '0;
    repeat (8) @(posedge ref_clk);
    #1 reset = 1'b0;
    acc(0, 0, 8'h00, 8'h00); chk("ctl0", rv, mbx_pkg::CTL0_RESET);
    acc(0, 0, 8'h08, 8'h00); chk("ctl1", rv, mbx_pkg::CTL1_RESET);
    acc(1, 0, 8'h01, 8'h00); chk("stat0", rv, 8'h02);
    acc(0, 0, 8'h20, 8'h00); chk("unmapped", rv, 8'h00);
    // receive, two bytes: non-final byte must not interrupt
    acc(0, 1, 8'h00, 8'h15);
    acc(1, 1, 8'h02, 8'hA5);
    chk("pin early", {7'h00, interrupt_pin}, 8'h00);
    acc(1, 1, 8'h03, 8'h5A);
    #10 chk("pin fill", {7'h00, interrupt_pin}, 8'h01);
    acc(0, 0, 8'h01, 8'h00); chk("stat full", rv, 8'h11);
    acc(0, 0, 8'h10, 8'h00); chk("ltype", rv, 8'h10);
    #10 chk("pin clr", {7'h00, interrupt_pin}, 8'h00);
    acc(0, 0, 8'h02, 8'h00); chk("b0", rv, 8'hA5);
    acc(0, 0, 8'h03, 8'h00); chk("b1", rv, 8'h5A);
    acc(0, 0, 8'h01, 8'h00); chk("stat empty", rv, 8'h02);
    // reconfigure in two accesses, then drain goes upstream
    acc(0, 1, 8'h00, 8'h00);
    acc(0, 1, 8'h00, 8'h25);
    acc(1, 1, 8'h02, 8'h11);
    acc(1, 1, 8'h03, 8'h22);
    acc(0, 0, 8'h03, 8'h00);
    acc(0, 0, 8'h01, 8'h00); chk("stat drain", rv, 8'h22);
    for (i = 0; i < 200 && up_irq !== 1'b1; i++) #10;
    #1 chk("up drain", up_type, 8'h11);
    for (i = 0; i < 200 && up_irq !== 1'b0; i++) #10;
    acc(0, 0, 8'h01, 8'h00); chk("stat ack", rv, 8'h02);
    // transmit, four bytes: fill upstream, drain downstream at next control field
    acc(0, 1, 8'h08, 8'h3F);
    for (int k = 0; k < 4; k++) acc(0, 1, 8'h0A + 8'(k), 8'hC0 + 8'(k));
    for (i = 0; i < 200 && up_irq !== 1'b1; i++) #10;
    #1 chk("up fill", up_type, 8'h12);
    for (i = 0; i < 200 && up_irq !== 1'b0; i++) #10;
    for (int k = 0; k < 3; k++)
    begin
      acc(1, 0, 8'h0A + 8'(k), 8'h00); chk("tx byte", rv, 8'hC0 + 8'(k));
    end
    for (i = 0; i < 100 && scf_strobe !== 1'b1; i++) #10;
    acc(1, 0, 8'h0D, 8'h00); chk("tx last", rv, 8'hC3);
    chk("pin wait", {7'h00, interrupt_pin}, 8'h00);
    for (i = 0; i < 100 && scf_strobe !== 1'b1; i++) #10;
    #10 chk("pin drain", {7'h00, interrupt_pin}, 8'h01);
    acc(0, 0, 8'h10, 8'h00); chk("ltype tx", rv, 8'h13);
    acc(0, 0, 8'h09, 8'h00); chk("stat1", rv, 8'h02);
    // master role: nodes 2 and 5 pending together
    master_strap = 1'b1;
    node_type[23:16] = 8'h12;
    node_type[47:40] = 8'h13;
    node_pending = 16'h0024;
    repeat (6) @(posedge ref_clk);
    #1 chk("mpin", {7'h00, interrupt_pin}, 8'h01);
    acc(0, 0, 8'h12, 8'h00); chk("src near", rv, 8'h02);
    acc(0, 0, 8'h11, 8'h00); chk("type", rv, 8'h12);
    repeat (4) @(posedge ref_clk);
    #1 chk("clr cnt", 8'(clr_cnt), 8'h01);
    chk("clr node", {4'h0, clear_node}, 8'h02);
    chk("pin falls", 8'(pin_falls), 8'h01);
    chk("pin again", {7'h00, interrupt_pin}, 8'h01);
    acc(0, 0, 8'h12, 8'h00); chk("src far", rv, 8'h05);
    acc(0, 1, 8'h13, 8'hA3);
    chk("target", {target_brcst, 1'b0, target_peri, 1'b0, target_node}, 8'hA3);
    report_and_stop();
  end
endmodule // tb_node_message_mailbox
